// File: design/spims_defines.svh
// Register map, field positions and timing counts of the serial port.
`ifndef SPIMS_DEFINES_SVH
`define SPIMS_DEFINES_SVH
`define SPIMS_IDX_DR      8'h21
`define SPIMS_IDX_CR      8'h22
`define SPIMS_IDX_CSR     8'h23
`define SPIMS_ADDR_DR     8'h84
`define SPIMS_ADDR_CR     8'h88
`define SPIMS_ADDR_CSR    8'h8c
`define SPIMS_CR_IE       7
`define SPIMS_CR_PE       6
`define SPIMS_CR_DIVEN    5
`define SPIMS_CR_MS       4
`define SPIMS_CR_CLOCK_POLARITY     3
`define SPIMS_CR_CLOCK_PHASE     2
`define SPIMS_CR_RATE_HI  1
`define SPIMS_CR_RATE_LO  0
`define SPIMS_CSR_TCF     7
`define SPIMS_CSR_WRITE_COLLISION_FLAG    6
`define SPIMS_CSR_OVR     5
`define SPIMS_CSR_MODE_FAULT_FLAG    4
`define SPIMS_CSR_SOD     2
`define SPIMS_CSR_SSM     1
`define SPIMS_CSR_SSI     0
`define SPIMS_MSB         7
`define SPIMS_LAST_EDGE   4'hf
`define SPIMS_HALF_DIV4   7'h02
`define SPIMS_HALF_DIV8   7'h04
`define SPIMS_HALF_DIV16  7'h08
`define SPIMS_HALF_DIV32  7'h10
`define SPIMS_HALF_DIV64  7'h20
`define SPIMS_HALF_DIV128 7'h40
`endif

// File: design/spims_pkg.sv
// Types of the serial port: transfer state and the state record.
package spims_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_BUSY = 2'h2
    } spims_state_t;

    typedef struct packed {
        spims_state_t st;
        logic [7:0]   cr;
        logic [7:0]   sh;
        logic [7:0]   rxbuf;
        logic         tcf;
        logic         write_collision_flag;
        logic         overrun_flag;
        logic         mode_fault_flag;
        logic         csr_seen;
        logic         mode_fault_flag_seen;
        logic         output_disable;
        logic         select_source;
        logic         internal_select;
        logic [6:0]   cnt;
        logic [3:0]   idx;
        logic         dout;
        logic         sck;
        logic         sck_oe;
        logic         mosi_oe;
        logic         miso_oe;
        logic         ss_s1;
        logic         ss_s2;
        logic         sck_s1;
        logic         sck_s2;
        logic         sck_s3;
        logic         mosi_s1;
        logic         mosi_s2;
        logic         miso_s1;
        logic         miso_s2;
        logic [31:0]  prdata;
        logic         pready;
        logic         pslverr;
        logic         irq;
    } spims_regs_t;
endpackage : spims_pkg

// File: design/spims_top.sv
// Serial peripheral port, master or slave, with an APB register slave.
`include "spims_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module spims_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    output var  logic              irq,
    input  wire logic              ss_n_i,
    input  wire logic              sck_i,
    output var  logic              sck_o,
    output var  logic              sck_oe,
    input  wire logic              mosi_i,
    output var  logic              mosi_o,
    output var  logic              mosi_oe,
    input  wire logic              miso_i,
    output var  logic              miso_o,
    output var  logic              miso_oe
);
    if (ADDR_W < 8)
    begin : g_bad_addr
        $error("spims_top: ADDR_W must be at least 8");
    end

    spims_pkg::spims_regs_t s;
    spims_pkg::spims_regs_t n;

    logic       master;
    logic       pe;
    logic       clock_polarity;
    logic       clock_phase;
    logic       ss_low;
    logic       din;
    logic       slave_edge;
    logic       do_edge;
    logic       done;
    logic       rd_setup;
    logic       wr_acc;
    logic       dr_wr;
    logic       dr_wr_ok;
    logic [7:0] wd;
    logic [7:0] cr_wd;

    // Half of the serial clock period in CPU clocks.
    function automatic logic [6:0] spims_half(input logic [7:0] cr);
        logic [2:0] sel;
        sel = {cr[`SPIMS_CR_DIVEN], cr[`SPIMS_CR_RATE_HI],
               cr[`SPIMS_CR_RATE_LO]};
        case (sel)
            3'h4:    spims_half = `SPIMS_HALF_DIV4;
            3'h0:    spims_half = `SPIMS_HALF_DIV8;
            3'h1:    spims_half = `SPIMS_HALF_DIV16;
            3'h6:    spims_half = `SPIMS_HALF_DIV32;
            3'h2:    spims_half = `SPIMS_HALF_DIV64;
            3'h3:    spims_half = `SPIMS_HALF_DIV128;
            3'h5:    spims_half = `SPIMS_HALF_DIV4;
            default: spims_half = `SPIMS_HALF_DIV32;
        endcase
    endfunction : spims_half

    function automatic logic [7:0] spims_idx_addr(input logic [7:0] a);
        spims_idx_addr = {2'h0, a[7:2]};
    endfunction : spims_idx_addr

    always_comb
    begin
        n = s;
        // Pins come from another clock domain, so two flops first.
        n.ss_s1   = ss_n_i;
        n.ss_s2   = s.ss_s1;
        n.sck_s1  = sck_i;
        n.sck_s2  = s.sck_s1;
        n.sck_s3  = s.sck_s2;
        n.mosi_s1 = mosi_i;
        n.mosi_s2 = s.mosi_s1;
        n.miso_s1 = miso_i;
        n.miso_s2 = s.miso_s1;

        master = s.cr[`SPIMS_CR_MS];
        pe     = s.cr[`SPIMS_CR_PE];
        clock_polarity   = s.cr[`SPIMS_CR_CLOCK_POLARITY];
        clock_phase   = s.cr[`SPIMS_CR_CLOCK_PHASE];
        ss_low = s.select_source ? ~s.internal_select : ~s.ss_s2;
        // The far slave answers our own clock, so one flop keeps the
        // divide-by-4 capture in time; a second would see a stale bit.
        din    = master ? s.miso_s1 : s.mosi_s2;
        // A slave follows the far clock; rates do not matter here.
        slave_edge = pe & ~master & ss_low
                     & (s.sck_s2 ^ s.sck_s3);
        do_edge  = 1'b0;
        done     = 1'b0;
        rd_setup = psel & ~penable & ~pwrite;
        wr_acc   = psel & penable & pwrite & s.pready;
        wd       = pwdata[7:0];
        cr_wd    = wd;
        dr_wr    = wr_acc
                   & (spims_idx_addr(paddr[7:0]) == `SPIMS_IDX_DR);
        dr_wr_ok = dr_wr & ~(s.tcf & ~s.csr_seen);

        case (s.st)
            spims_pkg::ST_IDLE:
            begin
                n.dout = s.sh[`SPIMS_MSB];
                n.sck  = clock_polarity;
                n.idx  = 4'h0;
                if (slave_edge)
                begin
                    n.st    = spims_pkg::ST_BUSY;
                    do_edge = 1'b1;
                end
            end
            spims_pkg::ST_BUSY:
            begin
                if (master)
                begin
                    if (s.cnt == 7'h00)
                    begin
                        n.cnt   = spims_half(s.cr) - 7'h01;
                        n.sck   = ~s.sck;
                        do_edge = 1'b1;
                    end
                    else
                    begin
                        n.cnt = s.cnt - 7'h01;
                    end
                end
                else if (!ss_low || !pe)
                begin
                    n.st = spims_pkg::ST_IDLE;
                end
                else
                begin
                    do_edge = slave_edge;
                end
            end
            default:
            begin
                n.st = spims_pkg::ST_IDLE;
            end
        endcase

        if (do_edge)
        begin
            n.idx = s.idx + 4'h1;
            if (s.idx[0] == clock_phase)
            begin
                n.sh = {s.sh[6:0], din};
            end
            else
            begin
                n.dout = s.sh[`SPIMS_MSB];
            end
            if (s.idx == `SPIMS_LAST_EDGE)
            begin
                done = 1'b1;
                n.st = spims_pkg::ST_IDLE;
            end
        end

        // Register reads act in the setup cycle, the cycle whose state
        // prdata shows, so no event can slip between view and clear.
        n.pready  = psel & ~penable;
        n.pslverr = 1'b0;
        n.prdata  = 32'h0000_0000;
        if (psel && !penable)
        begin
            case (paddr[7:0])
                `SPIMS_ADDR_DR:  n.prdata = {24'h00_0000, s.rxbuf};
                `SPIMS_ADDR_CR:  n.prdata = {24'h00_0000, s.cr};
                `SPIMS_ADDR_CSR: n.prdata = {24'h00_0000, s.tcf, s.write_collision_flag,
                                             s.overrun_flag, s.mode_fault_flag, 1'b0, s.output_disable,
                                             s.select_source, s.internal_select};
                default:         n.pslverr = 1'b1;
            endcase
            if (paddr[ADDR_W-1:0] != {{(ADDR_W-8){1'b0}}, paddr[7:0]})
            begin
                n.pslverr = 1'b1;
            end
        end

        if (rd_setup && paddr[7:0] == `SPIMS_ADDR_CSR)
        begin
            n.csr_seen = 1'b1;
            n.overrun_flag      = 1'b0;
            if (s.mode_fault_flag)
            begin
                n.mode_fault_flag_seen = 1'b1;
            end
        end
        if (rd_setup && paddr[7:0] == `SPIMS_ADDR_DR && s.csr_seen)
        begin
            n.tcf      = 1'b0;
            n.write_collision_flag     = 1'b0;
            n.csr_seen = 1'b0;
        end

        if (dr_wr_ok)
        begin
            if (s.csr_seen)
            begin
                n.tcf      = 1'b0;
                n.csr_seen = 1'b0;
            end
            if (s.st == spims_pkg::ST_BUSY)
            begin
                // The running byte keeps going untouched.
                n.write_collision_flag = 1'b1;
            end
            else
            begin
                n.sh   = wd;
                n.dout = wd[`SPIMS_MSB];
                if (master && pe)
                begin
                    n.st  = spims_pkg::ST_BUSY;
                    n.cnt = spims_half(s.cr) - 7'h01;
                end
            end
        end

        if (wr_acc && paddr[7:0] == `SPIMS_ADDR_CR)
        begin
            if (s.mode_fault_flag && !s.mode_fault_flag_seen)
            begin
                cr_wd[`SPIMS_CR_PE] = wd[`SPIMS_CR_PE]
                                      & s.cr[`SPIMS_CR_PE];
                cr_wd[`SPIMS_CR_MS] = wd[`SPIMS_CR_MS]
                                      & s.cr[`SPIMS_CR_MS];
            end
            n.cr = cr_wd;
            if (s.mode_fault_flag_seen)
            begin
                n.mode_fault_flag      = 1'b0;
                n.mode_fault_flag_seen = 1'b0;
            end
        end
        if (wr_acc && paddr[7:0] == `SPIMS_ADDR_CSR)
        begin
            n.output_disable = wd[`SPIMS_CSR_SOD];
            n.select_source = wd[`SPIMS_CSR_SSM];
            n.internal_select = wd[`SPIMS_CSR_SSI];
        end

        // Hardware events come last so a set beats a clear.
        if (done)
        begin
            n.tcf = 1'b1;
            if (s.tcf)
            begin
                n.overrun_flag = 1'b1;
            end
            else
            begin
                n.rxbuf = n.sh;
            end
        end
        if (master && ss_low)
        begin
            n.mode_fault_flag                = 1'b1;
            n.cr[`SPIMS_CR_MS]    = 1'b0;
            n.cr[`SPIMS_CR_PE]    = 1'b0;
            n.st                  = spims_pkg::ST_IDLE;
        end

        n.sck_oe  = n.cr[`SPIMS_CR_PE] & n.cr[`SPIMS_CR_MS];
        n.mosi_oe = n.sck_oe & ~n.output_disable;
        n.miso_oe = n.cr[`SPIMS_CR_PE] & ~n.cr[`SPIMS_CR_MS]
                    & ~n.output_disable & ss_low;
        n.irq     = n.cr[`SPIMS_CR_IE] & (n.tcf | n.overrun_flag | n.mode_fault_flag);
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s    <= '0;
            s.st <= spims_pkg::ST_IDLE;
        end
        else
        begin
            s <= n;
        end
    end

    assign prdata  = s.prdata;
    assign pready  = s.pready;
    assign pslverr = s.pslverr;
    assign irq     = s.irq;
    assign sck_o   = s.sck;
    assign sck_oe  = s.sck_oe;
    assign mosi_o  = s.dout;
    assign mosi_oe = s.mosi_oe;
    assign miso_o  = s.dout;
    assign miso_oe = s.miso_oe;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_write_blocked: assert property (
        dr_wr && s.tcf && !s.csr_seen && s.st == spims_pkg::ST_IDLE
        && !slave_edge
        |=> $stable(s.sh) && s.st == spims_pkg::ST_IDLE)
        else $error("data write taken while flag unread");

    a_fault_drops: assert property (
        master && ss_low
        |=> s.mode_fault_flag && !s.cr[`SPIMS_CR_MS] && !s.cr[`SPIMS_CR_PE])
        else $error("mode fault did not drop master");

    a_idle_level: assert property (
        s.st == spims_pkg::ST_IDLE |=> s.sck == $past(clock_polarity))
        else $error("clock not at idle level");

    a_collision: assert property (
        dr_wr_ok && s.st == spims_pkg::ST_BUSY
        |=> s.write_collision_flag)
        else $error("collision not flagged");

    a_overrun: assert property (
        done && s.tcf |=> s.overrun_flag && $stable(s.rxbuf))
        else $error("overrun missed or buffer overwritten");

    a_rx_copy: assert property (
        done && !s.tcf |=> s.tcf && s.rxbuf == $past(n.sh))
        else $error("received byte not copied");

    a_out_release: assert property (
        s.output_disable |-> !s.mosi_oe && !s.miso_oe)
        else $error("data output driven while disabled");

    a_div4_edge: assert property (
        s.st == spims_pkg::ST_BUSY && master && s.cnt == 7'h00
        && s.cr[`SPIMS_CR_DIVEN] && s.cr[1:0] == 2'h0 && !ss_low
        |=> s.sck != $past(s.sck) ##1 s.sck == $past(s.sck))
        else $error("divide by four half period wrong");

    a_irq_flags: assert property (
        s.irq |-> s.cr[`SPIMS_CR_IE] && (s.tcf || s.overrun_flag || s.mode_fault_flag))
        else $error("interrupt without enabled flag");
endmodule : spims_top

`default_nettype wire

// File: sim/spi_master_slave_port_tb.sv
// Self-checking bench of the serial port over its APB registers.
`include "spims_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module spi_master_slave_port_tb;
    localparam logic [7:0] adr_dr = `SPIMS_ADDR_DR;
    localparam logic [7:0] adr_cr = `SPIMS_ADDR_CR;
    localparam logic [7:0] adr_sr = `SPIMS_ADDR_CSR;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] rdata;
    logic        perr;
    logic        pready, pslverr, irq, sck_o, sck_oe, miso_i;
    logic        mosi_o, mosi_oe, miso_o, miso_oe;
    logic        ss_n_i = 1'b1;
    logic        sck_i = 1'b0;
    logic        mosi_i = 1'b0;
    logic        arm = 1'b0;
    logic        clock_phase_m = 1'b0;
    logic [7:0]  m_tx = 8'h00;
    logic [7:0]  m_rx;
    int          miscompares = 0;
    int          comparisons = 0;

    always #2 mclk = ~mclk;

    spims_top DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .ss_n_i(ss_n_i),
        .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_i),
        .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_i),
        .miso_o(miso_o), .miso_oe(miso_oe));

    spims_slave_model model (.sck(sck_o), .mosi(mosi_o), .clock_phase(clock_phase_m),
        .arm(arm), .tx_byte(m_tx), .miso(miso_i), .rx_byte(m_rx));

    task complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Two idle edges after each access let registered outputs settle.
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(negedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n == 20)
            miscompares++;
        rdata = prdata;
        perr = pslverr;
        @(posedge mclk);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : apb

    task xfer(input logic [7:0] cr, tx, rx, input int half, mode);
        int   n;
        logic s;
        logic moved;
        apb(1'b1, adr_cr, 32'h0000_0000);
        apb(1'b1, adr_cr, {24'h0, cr});
        clock_phase_m <= cr[2];
        m_tx <= rx;
        arm <= 1'b1;
        @(posedge mclk);
        arm <= 1'b0;
        check(sck_o, cr[3]);
        check({sck_oe, mosi_oe}, 2'b11);
        apb(1'b1, adr_dr, {24'h0, tx});
        if (mode == 1)
            apb(1'b1, adr_dr, {24'h0, ~tx});
        if (mode == 0)
        begin
            for (int k = 0; k < 2; k++)
            begin
                n = 0;
                s = sck_o;
                while (sck_o === s && n < 300)
                begin
                    @(negedge mclk);
                    n++;
                end
            end
            check(n, half);
        end
        if (mode == 2)
        begin
            repeat (16 * half + 16) @(posedge mclk);
            apb(1'b1, adr_dr, 32'h0000_0000);
            s = sck_o;
            moved = 1'b0;
            repeat (3 * half) @(posedge mclk) moved |= (sck_o !== s);
            check(moved, 1'b0);
        end
        n = 0;
        do
        begin
            apb(1'b0, adr_sr, 32'h0000_0000);
            n++;
        end
        while (rdata[7] !== 1'b1 && n < 400);
        check(rdata, {24'h0, 1'b1, mode == 1, 6'h00});
        check(irq, cr[7]);
        apb(1'b0, adr_dr, 32'h0000_0000);
        check(rdata, {24'h0, rx});
        check(m_rx, tx);
        apb(1'b0, adr_sr, 32'h0000_0000);
        check(rdata, 32'h0000_0000);
        $display("transfer mode %0d half %0d done", mode, half);
    endtask : xfer

    task t_rates;
        logic [2:0] code [6] = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010,
                                 3'b011};
        int         hv [6] = '{2, 4, 8, 16, 32, 64};
        for (int i = 0; i < 6; i++)
            xfer({i[0], 1'b1, code[i][2], 1'b1, i[1], i[1] ^ i[0],
                  code[i][1:0]}, 8'h96 ^ 8'(i), 8'h3c ^ 8'(i), hv[i], 0);
    endtask : t_rates

    task t_fault;
        apb(1'b1, adr_cr, 32'h0000_00d0);
        ss_n_i <= 1'b0;
        repeat (6) @(posedge mclk);
        ss_n_i <= 1'b1;
        repeat (4) @(posedge mclk);
        check(irq, 1'b1);
        check(sck_oe, 1'b0);
        apb(1'b0, adr_cr, 32'h0000_0000);
        check(rdata, 32'h0000_0080);
        apb(1'b1, adr_cr, 32'h0000_00d0);
        apb(1'b0, adr_cr, 32'h0000_0000);
        check(rdata, 32'h0000_0080);
        apb(1'b0, adr_sr, 32'h0000_0000);
        check(rdata, 32'h0000_0010);
        apb(1'b1, adr_cr, 32'h0000_0000);
        apb(1'b0, adr_sr, 32'h0000_0000);
        check(rdata, 32'h0000_0000);
        $display("mode fault done");
    endtask : t_fault

    task t_pins;
        apb(1'b1, adr_cr, 32'h0000_0050);
        apb(1'b1, adr_sr, 32'h0000_0004);
        check(mosi_oe, 1'b0);
        apb(1'b1, adr_sr, 32'h0000_0003);
        ss_n_i <= 1'b0;
        repeat (6) @(posedge mclk);
        ss_n_i <= 1'b1;
        apb(1'b0, adr_sr, 32'h0000_0000);
        check(rdata, 32'h0000_0003);
        apb(1'b1, adr_cr, 32'h0000_0040);
        apb(1'b1, adr_sr, 32'h0000_0002);
        check({sck_oe, miso_oe}, 2'b01);
        apb(1'b1, adr_sr, 32'h0000_0003);
        check(miso_oe, 1'b0);
        $display("pin control done");
    endtask : t_pins

    task sbyte(input logic [7:0] b, output logic [7:0] got);
        for (int k = 7; k >= 0; k--)
        begin
            mosi_i <= b[k];
            repeat (6) @(posedge mclk);
            sck_i <= 1'b1;
            got[k] = miso_o;
            repeat (6) @(posedge mclk);
            sck_i <= 1'b0;
        end
        repeat (8) @(posedge mclk);
        mosi_i <= ~mosi_i;
    endtask : sbyte

    task t_slave;
        logic [7:0] g;
        apb(1'b1, adr_cr, 32'h0000_0043);
        apb(1'b1, adr_sr, 32'h0000_0000);
        apb(1'b1, adr_dr, 32'h0000_0069);
        ss_n_i <= 1'b0;
        repeat (6) @(posedge mclk);
        sbyte(8'ha5, g);
        check(g, 8'h69);
        sbyte(8'h3c, g);
        ss_n_i <= 1'b1;
        apb(1'b0, adr_sr, 32'h0000_0000);
        check(rdata, 32'h0000_00a0);
        apb(1'b0, adr_dr, 32'h0000_0000);
        check(rdata, 32'h0000_00a5);
        apb(1'b0, adr_sr, 32'h0000_0000);
        check(rdata, 32'h0000_0000);
        $display("slave receive done");
    endtask : t_slave

    initial
    begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        apb(1'b0, adr_sr, 32'h0000_0000);
        check(rdata, 32'h0000_0000);
        apb(1'b0, adr_cr, 32'h0000_0000);
        check(rdata & 32'h0000_00f0, 32'h0000_0000);
        apb(1'b0, 8'h90, 32'h0000_0000);
        check(perr, 1'b1);
        check(rdata, 32'h0000_0000);
        $display("reset values done");
        t_rates;
        xfer(8'h70, 8'h5a, 8'hc3, 2, 1);
        xfer(8'h70, 8'ha5, 8'h0f, 2, 2);
        t_fault;
        t_pins;
        t_slave;
        complete_run;
    end

    initial
    begin
        repeat (60000) @(posedge mclk);
        miscompares++;
        complete_run;
    end
endmodule : spi_master_slave_port_tb
`default_nettype wire

// File: sim/spims_slave_model.sv
// Behavioural external slave that answers the port while it is master.
`timescale 1ns/100ps
`default_nettype none

module spims_slave_model (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       clock_phase,
    input  wire logic       arm,
    input  wire logic [7:0] tx_byte,
    output var  logic       miso,
    output var  logic [7:0] rx_byte
);
    int         edges = 16;
    logic [7:0] sr = 8'h00;

    initial miso = 1'b0;
    initial rx_byte = 8'h00;

    // The bench sets the same phase here as in the port, and arms the
    // model once the port idles, so a polarity change is never counted.
    always @(posedge arm)
    begin
        edges = 0;
        sr = tx_byte;
        if (!clock_phase)
            miso = sr[7];
    end

    always @(sck)
    begin
        if (edges < 16)
        begin
            edges++;
            if ((edges % 2 == 1) == !clock_phase)
                rx_byte = {rx_byte[6:0], mosi};
            if (edges == 16)
                miso = ~miso; // Released line shows no stale bit.
            else if (!((edges % 2 == 1) == !clock_phase))
            begin
                if (clock_phase)
                begin
                    miso = sr[7];
                    sr = sr << 1;
                end
                else
                begin
                    sr = sr << 1;
                    miso = sr[7];
                end
            end
        end
    end
endmodule : spims_slave_model
`default_nettype wire
